// ==== src/cap_seq_defs.vh ====
`ifndef CAP_SEQ_DEFS_VH
`define CAP_SEQ_DEFS_VH
`define CLK_HZ            20000000
// register byte offsets (chosen placement, one word each, eight words for each bank)
`define OFF_CTRL0         12'h000
`define OFF_PROX_HOLD     12'h004
`define OFF_PROX_RECAL    12'h008
`define OFF_RECAL_LVL     12'h00C
`define OFF_STATUS        12'h010
`define OFF_PAIR          12'h014
`define OFF_RESULT_BASE   12'h02C
`define OFF_POS_BASE      12'h080
`define OFF_AMB_BASE      12'h0C0
// control word zero fields
`define CTRL_PWR_LSB      0
`define CTRL_SLEEP_LSB    2
`define CTRL_OSR_LSB      8
`define CTRL0_RESET       32'h00000000
`define PWR_FULL          2'b00
`define PWR_LOW           2'b10
`define OSR_256           2'b00
`define OSR_128           2'b01
// stage time in ns for each oversampling ratio
`define STAGE_NS_128      1536000
`define STAGE_NS_256      3072000
`define SLEEP_UNIT_MS     200
`define TOUCH_PERIOD_MS   25
`define FP_HOLD_MULT      16
`define LP_HOLD_MULT      4
`define RECAL_CYCLES      2
`endif

// ==== src/stage_timer.v ====
`timescale 1ns/1ps
module stage_timer #(
    parameter WIDTH = 24
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire             run,
    input  wire [WIDTH-1:0] limit,
    output reg              done
);
    reg [WIDTH-1:0] count;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= {WIDTH{1'b0}};
            done  <= 1'b0;
        end else if (!run) begin
            count <= {WIDTH{1'b0}};
            done  <= 1'b0;
        end else if (count + 1'b1 >= limit) begin
            count <= {WIDTH{1'b0}};
            done  <= 1'b1;
        end else begin
            count <= count + 1'b1;
            done  <= 1'b0;
        end
    end
endmodule // stage_timer

// ==== src/cap_sense_sequencer_proximity.v ====
`timescale 1ns/1ps
`include "cap_seq_defs.vh"
module cap_sense_sequencer_proximity #(
    parameter STAGES    = 8,
    parameter MS_CYCLES = 20000
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    output reg  [2:0]  sensor_input,
    output reg         conv_start,
    input  wire        conv_done,
    input  wire [15:0] conv_result,
    input  wire        proximity,
    input  wire        touch,
    input  wire [7:0]  touch_raw,
    output reg  [7:0]  button_active,
    output wire        cal_enable,
    output reg         force_recal,
    output wire        seq_busy
);
    localparam S_IDLE  = 2'd0;
    localparam S_CONV  = 2'd1;
    localparam S_SLEEP = 2'd2;
    localparam STAGE_CYC_128 = (`STAGE_NS_128 / 50);
    localparam STAGE_CYC_256 = (`STAGE_NS_256 / 50);
    localparam FP_MULT = `FP_HOLD_MULT, LP_MULT = `LP_HOLD_MULT, RECAL_N = `RECAL_CYCLES;

    reg [31:0] ctrl0;
    reg [3:0]  fullpower_hold_count;
    reg [3:0]  lowpower_hold_count;
    reg [9:0]  fullpower_recal_timeout;
    reg [5:0]  lowpower_recal_timeout;
    reg [7:0]  recal_threshold;
    reg [2:0]  last_step;
    reg [7:0]  pair_mask;
    reg [15:0] result   [0:STAGES-1];
    reg [15:0] pos_bank [0:STAGES-1];
    reg [15:0] ambient  [0:STAGES-1];

    reg [1:0]  state;
    reg [2:0]  step;
    reg        seq_end;
    reg [13:0] hold_left;
    reg        holding;
    reg [9:0]  over_count;
    reg [1:0]  recal_left;
    reg [23:0] stage_limit;
    reg [31:0] wait_limit;
    reg [31:0] wait_count;

    reg        ap_valid;
    reg        ap_write;
    reg [11:0] ap_addr;

    wire [1:0] pwr  = ctrl0[`CTRL_PWR_LSB+1:`CTRL_PWR_LSB];
    wire [1:0] sel  = ctrl0[`CTRL_SLEEP_LSB+1:`CTRL_SLEEP_LSB];
    wire [1:0] osr  = ctrl0[`CTRL_OSR_LSB+1:`CTRL_OSR_LSB];
    wire       full = (pwr == `PWR_FULL);
    wire       low  = (pwr == `PWR_LOW);
    wire       stage_done;
    wire       over;

    function [2:0] word_index;
        input [11:0] addr;
        input [11:0] base;
        reg   [11:0] diff;
        begin
            diff       = addr - base;
            word_index = diff[4:2];
        end
    endfunction

    function in_bank;
        input [11:0] addr;
        input [11:0] base;
        begin
            in_bank = (addr >= base) && (addr < base + 12'h020);
        end
    endfunction

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign seq_busy  = (state == S_CONV);

    always @* begin
        stage_limit = (osr == `OSR_128) ? STAGE_CYC_128[23:0] : STAGE_CYC_256[23:0];
    end

    stage_timer #(.WIDTH(24)) u_stage_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (state == S_CONV && !conv_done),
        .limit   (stage_limit),
        .done    (stage_done)
    );

    always @* begin
        if (touch)
            wait_limit = `TOUCH_PERIOD_MS * MS_CYCLES;
        else
            wait_limit = (sel + 32'd1) * `SLEEP_UNIT_MS * MS_CYCLES;
    end

    // AHB-Lite slave, zero wait state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= 12'h000;
        end else if (hready) begin
            ap_valid <= hsel && htrans[1];
            ap_write <= hwrite;
            ap_addr  <= haddr[11:0];
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl0                   <= `CTRL0_RESET;
            fullpower_hold_count    <= 4'h0;
            lowpower_hold_count     <= 4'h0;
            fullpower_recal_timeout <= 10'h000;
            lowpower_recal_timeout  <= 6'h00;
            recal_threshold         <= 8'h00;
            last_step               <= 3'h7;
            pair_mask               <= 8'h00;
        end else if (ap_valid && ap_write) begin
            case (ap_addr)
                `OFF_CTRL0: begin
                    ctrl0       <= {22'h0, hwdata[9:8], 4'h0, hwdata[3:0]};
                    last_step   <= hwdata[6:4];
                end
                `OFF_PROX_HOLD: begin
                    fullpower_hold_count <= hwdata[3:0];
                    lowpower_hold_count  <= hwdata[7:4];
                end
                `OFF_PROX_RECAL: begin
                    fullpower_recal_timeout <= hwdata[9:0];
                    lowpower_recal_timeout  <= hwdata[15:10];
                end
                `OFF_RECAL_LVL: recal_threshold <= hwdata[7:0];
                `OFF_PAIR:      pair_mask       <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            if (haddr[11:0] == `OFF_CTRL0)
                hrdata <= ctrl0 | {25'h0, last_step, 4'h0};
            else if (haddr[11:0] == `OFF_PROX_HOLD)
                hrdata <= {24'h0, lowpower_hold_count, fullpower_hold_count};
            else if (haddr[11:0] == `OFF_PROX_RECAL)
                hrdata <= {16'h0, lowpower_recal_timeout, fullpower_recal_timeout};
            else if (haddr[11:0] == `OFF_RECAL_LVL)
                hrdata <= {24'h0, recal_threshold};
            else if (haddr[11:0] == `OFF_STATUS)
                hrdata <= {24'h0, recal_left != 2'd0, holding, state, 1'b0, step};
            else if (haddr[11:0] == `OFF_PAIR)
                hrdata <= {24'h0, pair_mask};
            else if (in_bank(haddr[11:0], `OFF_RESULT_BASE))
                hrdata <= {16'h0, result[word_index(haddr[11:0], `OFF_RESULT_BASE)]};
            else if (in_bank(haddr[11:0], `OFF_POS_BASE))
                hrdata <= {16'h0, pos_bank[word_index(haddr[11:0], `OFF_POS_BASE)]};
            else if (in_bank(haddr[11:0], `OFF_AMB_BASE))
                hrdata <= {16'h0, ambient[word_index(haddr[11:0], `OFF_AMB_BASE)]};
            else
                hrdata <= 32'h00000000;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state        <= S_IDLE;
            step         <= 3'h0;
            conv_start   <= 1'b0;
            sensor_input <= 3'h0;
            seq_end      <= 1'b0;
            wait_count   <= 32'h00000000;
        end else begin
            conv_start <= 1'b0;
            seq_end    <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (full || low) begin
                        state        <= S_CONV;
                        step         <= 3'h0;
                        sensor_input <= 3'h0;
                        conv_start   <= 1'b1;
                    end
                end
                S_CONV: begin
                    if (stage_done) begin
                        if (!(full || low)) begin
                            state <= S_IDLE;
                        end else if (step == last_step) begin
                            seq_end <= 1'b1;
                            step    <= 3'h0;
                            if (low) begin
                                state      <= S_SLEEP;
                                wait_count <= 32'h00000000;
                            end else begin
                                sensor_input <= 3'h0;
                                conv_start   <= 1'b1;
                            end
                        end else begin
                            step         <= step + 3'h1;
                            sensor_input <= step + 3'h1;
                            conv_start   <= 1'b1;
                        end
                    end
                end
                S_SLEEP: begin
                    if (!low) begin
                        state <= S_IDLE;
                    end else if (wait_count + 32'd1 >= wait_limit) begin
                        state        <= S_CONV;
                        sensor_input <= 3'h0;
                        conv_start   <= 1'b1;
                    end else begin
                        wait_count <= wait_count + 32'd1;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // results land when each stage ends
    integer i;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (i = 0; i < STAGES; i = i + 1) begin
                result[i]   <= 16'h0000;
                pos_bank[i] <= 16'h0000;
                ambient[i]  <= 16'h0000;
            end
        end else if (state == S_CONV && stage_done) begin
            result[step]   <= conv_result;
            pos_bank[step] <= conv_result;
            if (cal_enable || force_recal)
                ambient[step] <= conv_result;
        end
    end

    // over-threshold test against the ambient of the stage just finished
    assign over = (conv_result > ambient[step]) &&
                  (conv_result - ambient[step] > {8'h00, recal_threshold});

    // proximity hold and forced recalibration, counted in sequences
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            holding     <= 1'b0;
            hold_left   <= 14'h0000;
            over_count  <= 10'h000;
            recal_left  <= 2'd0;
            force_recal <= 1'b0;
        end else begin
            force_recal <= (recal_left != 2'd0);
            if (proximity || touch) begin
                holding   <= 1'b1;
                hold_left <= full ? {10'h000, fullpower_hold_count} * FP_MULT[13:0]
                                  : {10'h000, lowpower_hold_count} * LP_MULT[13:0];
            end else if (holding && seq_end) begin
                if (hold_left <= 14'h0001)
                    holding <= 1'b0;
                else
                    hold_left <= hold_left - 14'h0001;
            end
            if (seq_end && recal_left != 2'd0) begin
                recal_left <= recal_left - 2'd1;
            end else if (state == S_CONV && stage_done) begin
                if (!over || !holding)
                    over_count <= 10'h000;
                else if (over_count + 10'h001 >=
                         (full ? fullpower_recal_timeout
                               : {4'h0, lowpower_recal_timeout})) begin
                    over_count <= 10'h000;
                    recal_left <= RECAL_N[1:0];
                end else if (step == last_step) begin
                    over_count <= over_count + 10'h001;
                end
            end
        end
    end

    assign cal_enable = !holding && !proximity && !touch;

    // differential pairs: bit k of pair_mask pairs button 2k with 2k+1
    integer p;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            button_active <= 8'h00;
        end else begin
            button_active <= touch_raw;
            for (p = 0; p < 4; p = p + 1)
                if (pair_mask[p] && touch_raw[2*p] && touch_raw[2*p+1]) begin
                    button_active[2*p]   <= 1'b0;
                    button_active[2*p+1] <= 1'b0;
                end
        end
    end
endmodule // cap_sense_sequencer_proximity

// ==== dv/cap_seq_checker_properties.sv ====
`timescale 1ns/1ps
module cap_seq_checker (
    input wire       hclk,
    input wire       hresetn,
    input wire       hreadyout,
    input wire       hresp,
    input wire [2:0] sensor_input,
    input wire       conv_start,
    input wire       proximity,
    input wire       touch,
    input wire [7:0] touch_raw,
    input wire [7:0] button_active,
    input wire       cal_enable,
    input wire       force_recal,
    input wire       seq_busy
);
    reg [2:0] prev_step;

    // seeded with 7 so the first stage after reset must be step 0
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            prev_step <= 3'h7;
        else if (conv_start)
            prev_step <= sensor_input;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence quiet_gap;
        !conv_start [*8];
    endsequence
    sequence recal_hold;
        force_recal [*8];
    endsequence

    chk_cal_prox:
        assert property (proximity |-> !cal_enable) else $error("calibration on in proximity");
    chk_hold_after:
        assert property ($fell(proximity) |-> !cal_enable) else $error("calibration on right after proximity");
    chk_cal_touch:
        assert property (touch |-> !cal_enable) else $error("calibration on while touched");
    chk_step_order:
        assert property (conv_start |-> (sensor_input == 3'h0 || sensor_input == prev_step + 3'h1))
        else $error("stage order broken");
    chk_stage_gap:
        assert property (conv_start |=> quiet_gap) else $error("stage start too soon");
    chk_recal_len:
        assert property ($rose(force_recal) |-> recal_hold) else $error("recal too short");
    chk_pair_subset:
        assert property ((button_active & ~$past(touch_raw)) == 8'h00)
        else $error("button active without press");
    chk_busy_start:
        assert property (conv_start |-> seq_busy) else $error("stage start while idle");
    chk_bus_okay:
        assert property (hreadyout && !hresp) else $error("bus not ready or error");
endmodule // cap_seq_checker

bind cap_sense_sequencer_proximity cap_seq_checker u_checker (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .sensor_input(sensor_input), .conv_start(conv_start), .proximity(proximity),
    .touch(touch), .touch_raw(touch_raw), .button_active(button_active),
    .cal_enable(cal_enable), .force_recal(force_recal), .seq_busy(seq_busy));

// ==== dv/cap_sensor_model.sv ====
`timescale 1ns/1ps
module cap_sensor_model (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire [2:0]  sensor_input,
    input  wire        conv_start,
    input  wire        restart,
    output reg  [15:0] conv_result,
    output wire        conv_done
);
    // restart lets the bench restart the timing of the running stage after a mode change
    assign conv_done = restart;

    // each stage sees its own sensor, tagged by step so results are traceable
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            conv_result <= 16'h5555;
        else if (conv_start)
            conv_result <= 16'hA000 | {13'h0000, sensor_input};
    end
endmodule // cap_sensor_model

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`include "cap_seq_defs.vh"
module tb;
    localparam STAGE_CYC = `STAGE_NS_128 / 50;
    localparam TIMEOUT   = 100000;
    localparam MS_CYC    = 20;
    reg         hclk = 1'b0;
    reg         hresetn = 1'b0;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h00000000;
    reg  [1:0]  htrans = 2'b00;
    reg         hwrite = 1'b0;
    reg  [2:0]  hsize = 3'b010;
    reg  [31:0] hwdata = 32'h00000000;
    reg         restart = 1'b0;
    reg         proximity = 1'b0;
    reg         touch = 1'b0;
    reg  [7:0]  touch_raw = 8'h00;
    wire        hreadyout;
    wire        hresp;
    wire [31:0] hrdata;
    wire [2:0]  sensor_input;
    wire        conv_start;
    wire        conv_done;
    wire [15:0] conv_result;
    wire [7:0]  button_active;
    wire        cal_enable;
    wire        force_recal;
    wire        seq_busy;
    int         mismatches = 0;
    int         n_checks = 0;
    int         cycles = 0;
    logic [31:0] rd;

    always #25 hclk = ~hclk;

    cap_sense_sequencer_proximity #(.STAGES(8), .MS_CYCLES(MS_CYC)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sensor_input(sensor_input), .conv_start(conv_start), .conv_done(conv_done),
        .conv_result(conv_result), .proximity(proximity), .touch(touch),
        .touch_raw(touch_raw), .button_active(button_active), .cal_enable(cal_enable),
        .force_recal(force_recal), .seq_busy(seq_busy));

    cap_sensor_model partner (
        .hclk(hclk), .hresetn(hresetn), .sensor_input(sensor_input),
        .conv_start(conv_start), .restart(restart), .conv_result(conv_result),
        .conv_done(conv_done));

    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // a hang anywhere lands in the same closing report
    always @(posedge hclk) begin
        cycles = cycles + 1;
        if (cycles == TIMEOUT) begin
            mismatches = mismatches + 1;
            $display("BAD timeout expected end seen %0d cycles", cycles);
            end_sim;
        end
    end

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task ahb_cycle(input logic [31:0] a, input logic wr, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task ahb_write(input logic [31:0] a, input logic [31:0] d);
        ahb_cycle(a, 1'b1, d);
    endtask

    task ahb_read(input logic [31:0] a, input logic [31:0] exp, input string what);
        ahb_cycle(a, 1'b0, 32'h00000000);
        check(what, exp, rd);
    endtask

    task t_reset;
        ahb_read(32'h00000000, 32'h00000070, "ctrl0 reset");
        ahb_read(32'h000000FC, 32'h00000000, "unmapped read");
        check("cal_enable idle", 32'h00000001, {31'h0, cal_enable});
        $display("test reset done");
    endtask

    task t_regs;
        ahb_write(32'h00000004, 32'h00000021);
        ahb_read(32'h00000004, 32'h00000021, "hold counts");
        ahb_write(32'h00000008, 32'h00000401);
        ahb_read(32'h00000008, 32'h00000401, "recal counts");
        ahb_write(32'h0000000C, 32'h0000000B);
        ahb_read(32'h0000000C, 32'h0000000B, "recal level");
        ahb_write(32'h000000FC, 32'h12345678);
        ahb_read(32'h000000FC, 32'h00000000, "unmapped write");
        $display("test regs done");
    endtask

    // two stages at ratio 128 with the longest sleep code
    task t_seq;
        int n;
        ahb_write(32'h00000000, 32'h0000011C);
        ahb_read(32'h00000000, 32'h0000011C, "ctrl0 sleep osr");
        @(posedge hclk);
        restart <= 1'b1;
        @(posedge hclk);
        restart <= 1'b0;
        do @(posedge hclk); while (conv_start !== 1'b1);
        check("second step", 32'h00000001, {29'h0, sensor_input});
        n = 0;
        do begin
            @(posedge hclk);
            n = n + 1;
        end while (conv_start !== 1'b1);
        check("wrap to first", 32'h00000000, {29'h0, sensor_input});
        check("stage cycles", STAGE_CYC, n);
        check("forced recal", 32'h00000001, {31'h0, force_recal});
        ahb_read(32'h0000002C, 32'h0000A000, "result 0");
        ahb_read(32'h00000030, 32'h0000A001, "result 1");
        ahb_read(32'h00000084, 32'h0000A001, "position 1");
        ahb_read(32'h000000C0, 32'h00000000, "ambient 0 held");
        ahb_read(32'h000000C4, 32'h0000A001, "ambient 1 recal");
        // low power with one stage, woken by touch rather than the long sleep
        ahb_write(32'h00000000, 32'h0000010E);
        touch <= 1'b1;
        do @(posedge hclk); while (seq_busy === 1'b1);
        n = 0;
        do begin
            @(posedge hclk);
            n = n + 1;
        end while (conv_start !== 1'b1);
        touch <= 1'b0;
        check("touch wake cycles", `TOUCH_PERIOD_MS * MS_CYC, n);
        check("wake step", 32'h00000000, {29'h0, sensor_input});
        $display("test sequence done");
    endtask

    task t_prox;
        @(posedge hclk);
        proximity <= 1'b1;
        @(posedge hclk);
        check("cal off prox", 32'h0, {31'h0, cal_enable});
        proximity <= 1'b0;
        touch <= 1'b1;
        @(posedge hclk);
        check("cal off touch", 32'h0, {31'h0, cal_enable});
        touch <= 1'b0;
        $display("test proximity done");
    endtask

    task t_pair;
        ahb_write(32'h00000014, 32'h00000000);
        touch_raw <= 8'h0C;
        repeat (3) @(posedge hclk);
        check("unpaired", 32'h0000000C, {24'h0, button_active});
        ahb_write(32'h00000014, 32'h000000FF);
        touch_raw <= 8'hFF;
        repeat (3) @(posedge hclk);
        check("both pressed", 32'h00000000, {24'h0, button_active});
        touch_raw <= 8'h01;
        repeat (3) @(posedge hclk);
        check("one pressed", 32'h00000001, {24'h0, button_active});
        $display("test pair done");
    endtask

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_regs;
        t_prox;
        t_pair;
        t_seq;
        end_sim;
    end
endmodule // tb
